// *** hw/uie_core.sv ***
// Enable and interrupt logic of an asynchronous serial transceiver.
// Assumes the shifter core supplies character events and a start-detect level on core_clk.
//
// Notes on behaviour
// - Receive pending, receive and transmit irq enables clear on reset and during soft reset.
// - Transmit buffer ready sets on reset and while soft reset applied or removed.
// - Receive and transmit enable bits clear only on power-up reset.
// - Receiver and transmitter run independently on one shared baud rate.
// - Receive disable finishes current character, else stops; start detection also stops.
// - Transmit disable still sends shift register and holding buffer contents.
// - Disabled idle transmitter: buffer writes update content but start nothing.
// - Setting transmit enable loads held character into shifter immediately.
// - Error characters leave receive pending unchanged unless error irq enabled.
// - Wake enable zero: every character sets pending; one: only addresses.
// - Receive pending clears on buffer read or service with start-edge enable zero.
// - Receive request only when pending flag and receive irq enable set.
// - Start-detect not readable; clearing start-edge enable clears and blocks it.
// - Buffer ready sets when buffer free; clears on service start or write.
// - Transmit request needs ready flag, transmit irq enable and global enable.
// - Transmit irq enable only gates the request, never the ready flag.
// - Separate receive and transmit interrupt request outputs.
// - Soft reset holds state and flags; set after power-up until cleared.
`timescale 1ns/1ps
module uie_core (
   input wire logic core_clk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Processor side
   input wire logic global_irq_enable,
   output logic rx_irq_req,
   output logic tx_irq_req,
   output logic rx_start_irq_req,
   // Shifter core side
   input wire logic baud_tick,
   input wire logic rx_start_seen,
   input wire logic rx_char_done,
   input wire logic [7:0] rx_char_data,
   input wire logic rx_char_error,
   input wire logic rx_char_addr,
   input wire logic tx_shift_done,
   output logic rx_run,
   output logic rx_start_detect_en,
   output logic tx_load,
   output logic [7:0] tx_shift_data,
   output logic soft_reset_out
);

   // ==========================================
   // Register state
   logic soft_reset_bit_r;
   logic rx_enable_bit_r;
   logic tx_enable_bit_r;
   logic rx_irq_enable_r;
   logic tx_irq_enable_r;
   logic rx_error_irq_enable_r;
   logic rx_wake_irq_enable_r;
   logic rx_start_edge_enable_r;
   logic rx_pending_flag_r;
   logic tx_buffer_ready_flag_r;
   logic [7:0] tx_holding_buffer_r;
   logic [7:0] rx_holding_buffer_r;
   logic tx_full_r;
   logic tx_busy_r;
   logic rx_busy_r;
   logic rx_start_detect_r;
   logic ack_pend_r;
   logic soft_reset_q_r;
   logic tx_commit_r;

   // ==========================================
   // Bus decode
   logic acc;
   logic wr_ctrl;
   logic wr_txbuf;
   logic rd_rxbuf;
   logic wr_ack;
   logic tx_move;
   logic rx_take;
   logic rx_sets;
   logic rx_start_ok;
   logic rx_idle_en;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // One wait state: request is taken on the edge where waitrequest is low
   assign acc = (avs_read | avs_write) & ~avs_waitrequest;
   assign wr_ctrl = acc & avs_write & hit(avs_address, uie_pkg::UIE_OFF_CTRL);
   assign wr_txbuf = acc & avs_write & hit(avs_address, uie_pkg::UIE_OFF_TXBUF);
   assign rd_rxbuf = acc & avs_read & hit(avs_address, uie_pkg::UIE_OFF_RXBUF);
   assign wr_ack = acc & avs_write & hit(avs_address, uie_pkg::UIE_OFF_ACK);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read | avs_write) & avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         avs_readdata <= uie_pkg::UIE_UNMAPPED_RD;
      end else if ((avs_read & avs_waitrequest)) begin
         if (hit(avs_address, uie_pkg::UIE_OFF_CTRL)) begin
            avs_readdata <= {24'h00_0000, rx_start_edge_enable_r, rx_wake_irq_enable_r, rx_error_irq_enable_r,
                             tx_irq_enable_r, rx_irq_enable_r, tx_enable_bit_r, rx_enable_bit_r, soft_reset_bit_r};
         end else if (hit(avs_address, uie_pkg::UIE_OFF_FLAGS)) begin
            // Start-detect is deliberately absent here
            avs_readdata <= {27'h000_0000, rx_busy_r, tx_full_r, tx_busy_r, tx_buffer_ready_flag_r,
                             rx_pending_flag_r};
         end else if (hit(avs_address, uie_pkg::UIE_OFF_TXBUF)) begin
            avs_readdata <= {24'h00_0000, tx_holding_buffer_r};
         end else if (hit(avs_address, uie_pkg::UIE_OFF_RXBUF)) begin
            avs_readdata <= {24'h00_0000, rx_holding_buffer_r};
         end else begin
            avs_readdata <= uie_pkg::UIE_UNMAPPED_RD;
         end
      end
   end

   // ==========================================
   // Control register
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         soft_reset_bit_r <= uie_pkg::UIE_SOFT_RESET_BIT_RST;
         rx_enable_bit_r <= 1'b0;
         tx_enable_bit_r <= 1'b0;
         rx_error_irq_enable_r <= 1'b0;
         rx_wake_irq_enable_r <= 1'b0;
         rx_start_edge_enable_r <= 1'b0;
      end else if (wr_ctrl) begin
         soft_reset_bit_r <= avs_writedata[uie_pkg::UIE_CTRL_SOFT_RESET_BIT];
         rx_enable_bit_r <= avs_writedata[uie_pkg::UIE_CTRL_RXEN];
         tx_enable_bit_r <= avs_writedata[uie_pkg::UIE_CTRL_TXEN];
         rx_error_irq_enable_r <= avs_writedata[uie_pkg::UIE_CTRL_RXEIE];
         rx_wake_irq_enable_r <= avs_writedata[uie_pkg::UIE_CTRL_RXWIE];
         rx_start_edge_enable_r <= avs_writedata[uie_pkg::UIE_CTRL_RXSE];
      end
   end

   // Receive and transmit interrupt enables are held clear during soft reset
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_irq_enable_r <= 1'b0;
         tx_irq_enable_r <= 1'b0;
      end else if (soft_reset_bit_r) begin
         rx_irq_enable_r <= 1'b0;
         tx_irq_enable_r <= 1'b0;
      end else if (wr_ctrl) begin
         rx_irq_enable_r <= avs_writedata[uie_pkg::UIE_CTRL_RXIE];
         tx_irq_enable_r <= avs_writedata[uie_pkg::UIE_CTRL_TXIE];
      end
   end

   // ==========================================
   // Transmit side
   // Holding buffer moves to the shifter when the shifter is free and the transmitter enabled or the character owed to the line
   assign tx_move = ~soft_reset_bit_r & tx_full_r & ~tx_busy_r & (tx_enable_bit_r | tx_commit_r);

   // A character written while enabled is owed to the line even if the enable drops first.
   // Writes while disabled only replace the content of such a character, or start nothing.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         tx_commit_r <= 1'b0;
      end else if (soft_reset_bit_r) begin
         tx_commit_r <= 1'b0;
      end else if (wr_txbuf & tx_enable_bit_r) begin
         tx_commit_r <= 1'b1;
      end else if (tx_move) begin
         tx_commit_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         tx_holding_buffer_r <= 8'h00;
      end else if (wr_txbuf) begin
         tx_holding_buffer_r <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         tx_full_r <= 1'b0;
      end else if (soft_reset_bit_r) begin
         tx_full_r <= 1'b0;
      end else if (wr_txbuf) begin
         tx_full_r <= 1'b1;
      end else if (tx_move) begin
         tx_full_r <= 1'b0;
      end
   end

   // Busy ends only when the shifter reports done or on soft reset, whatever the enable does
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         tx_busy_r <= 1'b0;
      end else if (soft_reset_bit_r) begin
         tx_busy_r <= 1'b0;
      end else if (tx_move) begin
         tx_busy_r <= 1'b1;
      end else if (tx_shift_done) begin
         tx_busy_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         tx_load <= 1'b0;
         tx_shift_data <= 8'h00;
      end else begin
         tx_load <= tx_move;
         if (tx_move) begin
            tx_shift_data <= tx_holding_buffer_r;
         end
      end
   end

   // Ready flag: set on reset and whole soft reset, set when buffer empties
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         tx_buffer_ready_flag_r <= 1'b1;
      end else if (soft_reset_bit_r) begin
         tx_buffer_ready_flag_r <= 1'b1;
      end else if (tx_move) begin
         tx_buffer_ready_flag_r <= 1'b1;
      end else if (wr_txbuf | (wr_ack & avs_writedata[uie_pkg::UIE_ACK_TX])) begin
         tx_buffer_ready_flag_r <= 1'b0;
      end
   end

   // ==========================================
   // Receive side
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_busy_r <= 1'b0;
      end else if (soft_reset_bit_r) begin
         rx_busy_r <= 1'b0;
      end else if (rx_start_ok) begin
         rx_busy_r <= 1'b1;
      end else if (rx_char_done) begin
         rx_busy_r <= 1'b0;
      end
   end

   // Character in flight is finished even after the enable drops
   assign rx_take = rx_char_done & rx_busy_r & ~soft_reset_bit_r;
   assign rx_sets = rx_take & (~rx_char_error | rx_error_irq_enable_r)
                    & (~rx_wake_irq_enable_r | rx_char_addr);

   // A start edge counts only for an enabled, idle receiver
   assign rx_start_ok = rx_start_seen & rx_enable_bit_r & ~rx_busy_r;
   // Detection stays off until the shifter has left its stretched reset
   assign rx_idle_en = rx_enable_bit_r & ~soft_reset_bit_r & ~soft_reset_q_r & ~rx_busy_r;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_holding_buffer_r <= 8'h00;
      end else if (rx_take & (~rx_wake_irq_enable_r | rx_char_addr)) begin
         rx_holding_buffer_r <= rx_char_data;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ack_pend_r <= 1'b0;
      end else begin
         ack_pend_r <= wr_ack & avs_writedata[uie_pkg::UIE_ACK_RX] & ~rx_start_edge_enable_r;
      end
   end

   // Set wins over a same-cycle clear
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_pending_flag_r <= 1'b0;
      end else if (soft_reset_bit_r) begin
         rx_pending_flag_r <= 1'b0;
      end else if (rx_sets) begin
         rx_pending_flag_r <= 1'b1;
      end else if (rd_rxbuf | ack_pend_r) begin
         rx_pending_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_start_detect_r <= 1'b0;
      end else if (soft_reset_bit_r | ~rx_start_edge_enable_r) begin
         rx_start_detect_r <= 1'b0;
      end else if (rx_start_ok) begin
         rx_start_detect_r <= 1'b1;
      end
   end

   // ==========================================
   // Request outputs
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_irq_req <= 1'b0;
         tx_irq_req <= 1'b0;
         rx_start_irq_req <= 1'b0;
      end else begin
         rx_irq_req <= rx_pending_flag_r & rx_irq_enable_r;
         tx_irq_req <= tx_buffer_ready_flag_r & tx_irq_enable_r & global_irq_enable;
         rx_start_irq_req <= rx_start_detect_r & global_irq_enable;
      end
   end

   // Receiver controls to the shifter
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_run <= 1'b0;
         rx_start_detect_en <= 1'b0;
      end else begin
         rx_run <= rx_busy_r | (rx_enable_bit_r & ~soft_reset_bit_r);
         rx_start_detect_en <= rx_idle_en & baud_tick |
                               rx_idle_en;
      end
   end

   // Soft reset to the shifter is stretched by one cycle on release
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         soft_reset_q_r <= 1'b1;
         soft_reset_out <= 1'b1;
      end else begin
         soft_reset_q_r <= soft_reset_bit_r;
         soft_reset_out <= soft_reset_q_r | soft_reset_bit_r;
      end
   end

endmodule : uie_core

// *** hw/uie_pkg.sv ***
// Package for the serial enable and interrupt logic: register map, field positions, reset values.
// Assumes a 32-bit Avalon-MM slave with waitrequest, word addressed by byte offset.
package uie_pkg;
   // ==========================================
   // Register offsets (byte addresses)
   localparam logic [7:0] UIE_OFF_CTRL = 8'h00;
   localparam logic [7:0] UIE_OFF_FLAGS = 8'h04;
   localparam logic [7:0] UIE_OFF_TXBUF = 8'h08;
   localparam logic [7:0] UIE_OFF_RXBUF = 8'h0c;
   localparam logic [7:0] UIE_OFF_ACK = 8'h10;
   // ==========================================
   // Control register fields
   localparam int UIE_CTRL_SOFT_RESET_BIT = 0;
   localparam int UIE_CTRL_RXEN = 1;
   localparam int UIE_CTRL_TXEN = 2;
   localparam int UIE_CTRL_RXIE = 3;
   localparam int UIE_CTRL_TXIE = 4;
   localparam int UIE_CTRL_RXEIE = 5;
   localparam int UIE_CTRL_RXWIE = 6;
   localparam int UIE_CTRL_RXSE = 7;
   // ==========================================
   // Flags register fields
   localparam int UIE_FLG_RXPEND = 0;
   localparam int UIE_FLG_TXRDY = 1;
   localparam int UIE_FLG_TXBUSY = 2;
   localparam int UIE_FLG_TXFULL = 3;
   localparam int UIE_FLG_RXBUSY = 4;
   // Acknowledge register fields (write one to acknowledge service start)
   localparam int UIE_ACK_RX = 0;
   localparam int UIE_ACK_TX = 1;
   // ==========================================
   // Reset values
   localparam logic UIE_SOFT_RESET_BIT_RST = 1'b1;
   localparam logic [31:0] UIE_UNMAPPED_RD = 32'h0000_0000;
endpackage : uie_pkg

// *** verif/uie_core_properties.sv ***
// Port checker for the serial enable and interrupt block.
// Assumes one clock, core_clk, and an asynchronous active-high reset.
`timescale 1ns/1ps
module uie_core_chk (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic global_irq_enable,
   input wire logic rx_irq_req,
   input wire logic tx_irq_req,
   input wire logic rx_start_irq_req,
   input wire logic rx_start_detect_en,
   input wire logic tx_load,
   input wire logic soft_reset_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // ==========================================
   // Sequences
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   sequence s_srst;
      soft_reset_out && $past(soft_reset_out);
   endsequence
   // ==========================================
   // Properties
   a_bus_answer: assert property (s_req |=> s_ans)
      else $error("bus answer not one cycle");
   a_bus_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
      else $error("waitrequest low without request");
   a_unmapped_read: assert property (avs_read && avs_address == 8'h14 && !avs_waitrequest |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_srst_irq_off: assert property (s_srst |-> !rx_irq_req && !tx_irq_req)
      else $error("irq during soft reset");
   a_srst_no_start: assert property (s_srst |-> !rx_start_detect_en)
      else $error("start detect during soft reset");
   a_tx_irq_gie: assert property (tx_irq_req |-> $past(global_irq_enable))
      else $error("tx irq without global enable");
   a_start_irq_gie: assert property (rx_start_irq_req |-> $past(global_irq_enable))
      else $error("start irq without global enable");
   a_load_single: assert property (tx_load |=> !tx_load [*3])
      else $error("tx load repeated while busy");
endmodule : uie_core_chk
bind uie_core uie_core_chk u_uie_core_chk (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .global_irq_enable(global_irq_enable), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req),
   .rx_start_irq_req(rx_start_irq_req), .rx_start_detect_en(rx_start_detect_en), .tx_load(tx_load),
   .soft_reset_out(soft_reset_out));

// *** verif/uie_core_tb.sv ***
// Self-checking testbench of the serial enable and interrupt block.
// Assumes the shifter model on the far side and an Avalon-MM master here.
`timescale 1ns/1ps
module uie_core_tb;
   localparam logic [7:0] A_C = uie_pkg::UIE_OFF_CTRL;
   localparam logic [7:0] A_F = uie_pkg::UIE_OFF_FLAGS;
   localparam logic [7:0] A_T = uie_pkg::UIE_OFF_TXBUF;
   localparam logic [7:0] A_R = uie_pkg::UIE_OFF_RXBUF;
   localparam logic [7:0] A_K = uie_pkg::UIE_OFF_ACK;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic global_irq_enable = 1'b0;
   logic rx_irq_req, tx_irq_req, rx_start_irq_req, baud_tick, rx_start_seen, rx_char_done;
   logic rx_char_error, rx_char_addr, tx_shift_done, rx_run, rx_start_detect_en, tx_load, soft_reset_out;
   logic [7:0] rx_char_data, tx_shift_data;
   logic [31:0] q;
   int failures = 0;
   int compares = 0;
   uie_core u_uie_core (.core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .global_irq_enable(global_irq_enable), .rx_irq_req(rx_irq_req),
      .tx_irq_req(tx_irq_req), .rx_start_irq_req(rx_start_irq_req), .baud_tick(baud_tick),
      .rx_start_seen(rx_start_seen), .rx_char_done(rx_char_done), .rx_char_data(rx_char_data),
      .rx_char_error(rx_char_error), .rx_char_addr(rx_char_addr), .tx_shift_done(tx_shift_done),
      .rx_run(rx_run), .rx_start_detect_en(rx_start_detect_en), .tx_load(tx_load),
      .tx_shift_data(tx_shift_data), .soft_reset_out(soft_reset_out));
   uie_shifter_model u_m (.core_clk(core_clk), .tx_load(tx_load), .tx_shift_data(tx_shift_data),
      .rx_start_detect_en(rx_start_detect_en), .baud_tick(baud_tick), .rx_start_seen(rx_start_seen),
      .rx_char_done(rx_char_done), .rx_char_data(rx_char_data), .rx_char_error(rx_char_error),
      .rx_char_addr(rx_char_addr), .tx_shift_done(tx_shift_done));
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   // ==========================================
   // Shared tasks
   task automatic test_done();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   task automatic chk(input logic g, input logic e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %0t got %b expected %b", $time, g, e);
      end
   endtask : chk
   task automatic rx_send(input logic [7:0] d, input logic e, input logic a);
      u_m.send(d, e, a);
      if (u_m.send_ok !== 1'b1) begin
         failures++;
         $display("[FAIL] %0t receiver never ready", $time);
         test_done();
      end
   endtask : rx_send
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (i == 20) begin
         failures++;
         test_done();
      end
   endtask : bus
   // ==========================================
   // Scenarios
   task automatic t_reset();
      bus(0, A_F, 0);
      chk(q[1], 1'b1);
      chk(q[0], 1'b0);
      bus(0, A_C, 0);
      chk(q[0], 1'b1);
      chk(q[1] | q[2], 1'b0);
      bus(1, A_C, 32'h0000_001f);
      bus(0, A_C, 0);
      chk(q[3] | q[4], 1'b0);
      chk(q[1] & q[2], 1'b1);
      bus(1, 8'h14, 32'h0000_00ff);
      bus(0, 8'h14, 0);
      chk(q === 32'h0, 1'b1);
      $display("test reset done");
   endtask : t_reset
   task automatic t_tx();
      bus(1, A_C, 32'h0);
      bus(1, A_T, 32'h0000_00a5);
      bus(0, A_F, 0);
      chk(q[1], 1'b0);
      repeat (20) @(posedge core_clk);
      chk(u_m.tx_count == 0, 1'b1);
      bus(1, A_C, 32'h0000_0014);
      repeat (3) @(posedge core_clk);
      chk(u_m.tx_count == 1 && u_m.tx_byte === 8'ha5, 1'b1);
      chk(tx_irq_req, 1'b0);
      global_irq_enable <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk(tx_irq_req, 1'b1);
      bus(1, A_C, 32'h0000_0004);
      repeat (2) @(posedge core_clk);
      chk(tx_irq_req, 1'b0);
      repeat (10) @(posedge core_clk);
      bus(1, A_T, 32'h0000_0011);
      bus(0, A_F, 0);
      chk(q[1], 1'b1);
      bus(1, A_T, 32'h0000_0022);
      bus(1, A_C, 32'h0);
      repeat (30) @(posedge core_clk);
      chk(u_m.tx_count == 3 && u_m.tx_byte === 8'h22, 1'b1);
      bus(1, A_K, 32'h0000_0002);
      bus(0, A_F, 0);
      chk(q[1], 1'b0);
      chk(q[3], 1'b0);
      bus(1, A_C, 32'h0000_0001);
      bus(0, A_F, 0);
      chk(q[1], 1'b1);
      chk(soft_reset_out, 1'b1);
      $display("test tx done");
   endtask : t_tx
   task automatic t_rx();
      bus(1, A_C, 32'h0000_000a);
      bus(0, A_C, 0);
      chk(q[3], 1'b0);
      bus(1, A_C, 32'h0000_000a);
      rx_send(8'h3c, 1'b0, 1'b0);
      repeat (3) @(posedge core_clk);
      chk(rx_irq_req, 1'b1);
      bus(0, A_R, 0);
      chk(q[7:0] === 8'h3c, 1'b1);
      repeat (2) @(posedge core_clk);
      chk(rx_irq_req, 1'b0);
      rx_send(8'h55, 1'b1, 1'b0);
      bus(0, A_F, 0);
      chk(q[0], 1'b0);
      bus(1, A_C, 32'h0000_0022);
      rx_send(8'h66, 1'b1, 1'b0);
      bus(0, A_F, 0);
      chk(q[0], 1'b1);
      chk(rx_irq_req, 1'b0);
      bus(1, A_K, 32'h0000_0001);
      repeat (2) @(posedge core_clk);
      bus(0, A_F, 0);
      chk(q[0], 1'b0);
      bus(1, A_C, 32'h0000_0042);
      rx_send(8'h77, 1'b0, 1'b0);
      bus(0, A_F, 0);
      chk(q[0], 1'b0);
      rx_send(8'h78, 1'b0, 1'b1);
      bus(0, A_F, 0);
      chk(q[0], 1'b1);
      bus(1, A_C, 32'h0000_0082);
      rx_send(8'h11, 1'b0, 1'b0);
      chk(rx_start_irq_req, 1'b1);
      bus(1, A_K, 32'h0000_0001);
      repeat (2) @(posedge core_clk);
      bus(0, A_F, 0);
      chk(q[0], 1'b1);
      bus(1, A_C, 32'h0000_0002);
      repeat (3) @(posedge core_clk);
      chk(rx_start_irq_req, 1'b0);
      bus(1, A_C, 32'h0);
      repeat (2) @(posedge core_clk);
      chk(rx_start_detect_en, 1'b0);
      chk(rx_run, 1'b0);
      $display("test rx done");
   endtask : t_rx
   initial begin
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_tx();
      t_rx();
      test_done();
   end
endmodule : uie_core_tb

// *** verif/uie_shifter_model.sv ***
// Behavioural shifter core facing the enable and interrupt block.
// Assumes the testbench calls send to deliver a received character.
`timescale 1ns/1ps
module uie_shifter_model (
   input wire logic core_clk,
   input wire logic tx_load,
   input wire logic [7:0] tx_shift_data,
   input wire logic rx_start_detect_en,
   output logic baud_tick = 1'b0,
   output logic rx_start_seen = 1'b0,
   output logic rx_char_done = 1'b0,
   output logic [7:0] rx_char_data = 8'h00,
   output logic rx_char_error = 1'b0,
   output logic rx_char_addr = 1'b0,
   output logic tx_shift_done = 1'b0
);
   logic send_ok = 1'b1;
   int tx_count = 0;
   int tx_left = 0;
   logic [7:0] tx_byte = 8'h00;
   // One shared tick for both directions, shift takes 8 cycles
   always @(posedge core_clk) begin
      baud_tick <= !baud_tick;
      tx_shift_done <= (tx_left == 1);
      if (tx_load) begin
         tx_left <= 8;
         tx_byte <= tx_shift_data;
         tx_count <= tx_count + 1;
      end else if (tx_left > 0) begin
         tx_left <= tx_left - 1;
      end
   end
   task automatic send(input logic [7:0] d, input logic e, input logic a);
      int i;
      for (i = 0; i < 50 && rx_start_detect_en !== 1'b1; i++) @(posedge core_clk);
      send_ok = (rx_start_detect_en === 1'b1);
      rx_start_seen <= 1'b1;
      @(posedge core_clk);
      rx_start_seen <= 1'b0;
      repeat (5) @(posedge core_clk);
      rx_char_data <= d;
      rx_char_error <= e;
      rx_char_addr <= a;
      rx_char_done <= 1'b1;
      @(posedge core_clk);
      rx_char_done <= 1'b0;
      // Released lines show the inverse of the last value
      rx_char_data <= ~d;
      rx_char_error <= ~e;
      rx_char_addr <= ~a;
   endtask : send
endmodule : uie_shifter_model
